// ==== design/spm_pkg.sv ====
// power manager package: register map, field positions, reset values, timing
// assumes a 200 MHz clock and a 32-bit avalon-mm register bus, 8-bit data
//
// Behaviour
// - direct powerdown register forces floppy, each uart, parallel port down.
// - floppy auto powerdown armed only while auto config bit 0 set.
// - floppy auto-down needs motors off, status 80h no interrupt, head unloaded, 10ms.
// - idle timer starts when auto powerdown enabled; down when all conditions hold.
// - clearing floppy auto enable cancels timer and keeps floppy awake.
// - rate register powerdown overrides auto powerdown; auto resumes after wake.
// - wake by bus reset or software reset bit runs normal reset sequence.
// - motor-enable write, main status read, data access wake floppy; output read doesn't.
// - output or rate writes wake only when setting motor or reset bits.
// - after wake the 10ms idle timer restarts; down again when conditions hold.
// - non-waking accesses keep unit down; reads true, writes retained.
// - bus pins stay fully functional during floppy auto powerdown.
// - floppy down tri-states motor, select, write data, gate; others stay active.
// - uart auto powerdown enabled by auto config bits 4 and 5.
// - uart transmitter down when buffer and shifter empty; wakes on buffer write.
// - uart receiver down only when receive fifo empty and awaiting start bit.
// - uart receiver wakes as soon as serial input changes.
// - ring indicator change stays reported while uart powered down.
// - parallel port auto powerdown enabled by auto config bit 3.
// - epp logic down if epp unconfigured, or ecp mode without ecr epp.
// - ecp logic down if ecp unconfigured, or ecr selects spp, ps2 or epp.
// - parallel port powerdown re-evaluated on any mode field change.

package spm_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [3:0] IDX_STATUS_A   = 4'h0;
  localparam logic [3:0] IDX_STATUS_B   = 4'h1;
  localparam logic [3:0] IDX_DRV_OUT    = 4'h2;
  localparam logic [3:0] IDX_RATE_MAIN  = 4'h4;  // rate select on write, main status on read
  localparam logic [3:0] IDX_DATA       = 4'h5;
  localparam logic [3:0] IDX_DIN_RATE   = 4'h7;  // drive input on read, rate control on write
  localparam logic [3:0] IDX_DIRECT_PD  = 4'h8;
  localparam logic [3:0] IDX_AUTO_PD    = 4'h9;
  localparam logic [3:0] IDX_PD_STATUS  = 4'ha;
  localparam logic [3:0] IDX_PPORT_MODE = 4'hb;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PD_FDC_BIT    = 0;  // same layout in direct and auto config
  localparam int PD_PPORT_BIT  = 3;
  localparam int PD_UART0_BIT  = 4;
  localparam int DOR_DSEL_BIT  = 0;
  localparam int DOR_RSTN_BIT  = 2;
  localparam int DOR_MOTOR_LSB = 4;
  localparam int DSR_PD_BIT    = 6;
  localparam int DSR_RST_BIT   = 7;
  localparam int PPM_EPP_BIT   = 0;
  localparam int PPM_ECP_BIT   = 1;
  localparam int PPM_ECR_LSB   = 2;

  // ------------------------------------------------------------------
  // values, encodings and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] MSR_IDLE = 8'h80;
  localparam logic [2:0] ECR_SPP  = 3'h0;
  localparam logic [2:0] ECR_PS2  = 3'h1;
  localparam logic [2:0] ECR_EPP  = 3'h4;
  localparam logic [7:0] DOR_RST  = 8'h04;
  localparam logic [7:0] CFG_RST  = 8'h00;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int IDLE_TIME_MS = 10;
  localparam int CLK_HZ       = 200000000;
  localparam int IDLE_CYC     = IDLE_TIME_MS * (CLK_HZ / 1000);
  localparam int TMR_W        = 22;

  // floppy drive outputs that are tri-stated in powerdown
  typedef struct packed {
    logic motor_on_n;
    logic drive_select_n;
    logic write_data_n;
    logic write_gate_n;
  } spm_fdd_drv_t;

endpackage

// ==== design/spm_power_manager.sv ====
// power manager for floppy, two uarts and parallel port, with register slave
// assumes synchronous inputs on clk and floppy / uart cores beside it
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps

module spm_power_manager #(
  parameter int IDLE_CYCLES = spm_pkg::IDLE_CYC  // 10 ms idle timer length
) (
  input  wire  logic                 clk,                 // 200 MHz clock
  input  wire  logic                 rst,                 // sync reset, active high
  input  wire  logic [5:0]           avs_address,         // byte address
  input  wire  logic                 avs_read,            // read request
  input  wire  logic                 avs_write,           // write request
  input  wire  logic [31:0]          avs_writedata,       // write data, low byte used
  input  wire  logic [3:0]           avs_byteenable,      // lane 0 gates writes
  output       logic [31:0]          avs_readdata,        // read data
  output       logic                 avs_waitrequest,     // stall request
  input  wire  logic                 bus_reset_n,         // bus reset pin
  input  wire  logic [7:0]           fdc_main_status,     // live main status
  input  wire  logic                 fdc_int,             // floppy interrupt
  input  wire  logic                 fdc_head_unloaded,   // head unload timer expired
  input  wire  logic [7:0]           fdc_rd_data,         // data register read value
  input  wire  logic [7:0]           fdc_status_a,        // live status a
  input  wire  logic [7:0]           fdc_status_b,        // live status b
  input  wire  logic                 disk_change_n,       // drive input pin
  output       logic                 fdc_data_rd,         // data register read pulse
  output       logic                 fdc_data_wr,         // data register write pulse
  output       logic [7:0]           fdc_wdata,           // data register write value
  output       logic                 fdc_reset_req,       // reset sequence pulse
  output       logic [7:0]           fdc_rate_ctrl,       // last rate write
  output       logic                 fdc_powered_down,    // floppy unit down
  input  wire  logic                 core_write_data_n,   // core write data
  input  wire  logic                 core_write_gate_n,   // core write gate
  input  wire  logic                 core_step_dir_n,     // core step direction
  input  wire  logic                 core_step_n,         // core step pulse
  input  wire  logic                 core_head_sel_n,     // core head select
  input  wire  logic [1:0]           core_density,        // core density select
  output       spm_pkg::spm_fdd_drv_t fdd_o,              // drive outputs
  output       spm_pkg::spm_fdd_drv_t fdd_oe,             // drive output enables
  output       logic                 step_direction_n,    // step direction pin
  output       logic                 step_pulse_n,        // step pulse pin
  output       logic                 head_select_n,       // head select pin
  output       logic [1:0]           density_select,      // density pins
  input  wire  logic [1:0]           uart_tx_write,       // transmit buffer write
  input  wire  logic [1:0]           uart_thr_empty,      // holding buffer empty
  input  wire  logic [1:0]           uart_tsr_empty,      // shift register empty
  input  wire  logic [1:0]           uart_rx_fifo_empty,  // receive fifo empty
  input  wire  logic [1:0]           uart_rx_idle,        // awaiting start bit
  input  wire  logic [1:0]           uart_serial_input,   // serial receive pins
  input  wire  logic [1:0]           ring_indicator_input,// ring indicator pins
  output       logic [1:0]           uart_tx_pd,          // transmitter down
  output       logic [1:0]           uart_rx_pd,          // receiver down
  output       logic [1:0]           uart_ring_change,    // ring change pulse
  output       logic                 pport_epp_pd,        // epp logic down
  output       logic                 pport_ecp_pd         // ecp logic down
);
  import spm_pkg::*;

  // ------------------------------------------------------------------
  // avalon slave: one wait state, answer on the second cycle
  // ------------------------------------------------------------------
  logic       ack_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  wire        req      = avs_read | avs_write;
  wire  [3:0] idx      = avs_address[5:2];
  wire        wr_fire  = avs_write & ack_r & avs_byteenable[0];
  wire        rd_fire  = avs_read & ack_r;
  wire  [7:0] wd       = avs_writedata[7:0];

  // bus side never gated by powerdown, so waking accesses are always seen
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata    = {24'h000000, rdata_r};

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  // ------------------------------------------------------------------
  // configuration and floppy registers
  // ------------------------------------------------------------------
  logic [7:0] dor_r;
  logic [7:0] dpd_r;
  logic [7:0] apd_r;
  logic [7:0] ppm_r;
  logic       dsr_pd_r;
  logic       fdc_auto_pd_r;
  logic [TMR_W-1:0] tmr_r;
  logic       apd_fdc_q_r;

  wire wr_dor  = wr_fire & hit(idx, IDX_DRV_OUT);
  wire wr_dsr  = wr_fire & hit(idx, IDX_RATE_MAIN);
  wire wr_ccr  = wr_fire & hit(idx, IDX_DIN_RATE);
  wire rd_msr  = rd_fire & hit(idx, IDX_RATE_MAIN);
  wire acc_dat = (rd_fire | wr_fire) & hit(idx, IDX_DATA);

  // waking events; plain output or rate writes do not count
  wire wake_motor = wr_dor & (wd[DOR_MOTOR_LSB+:4] != 4'h0);
  wire sw_rst     = (wr_dor & ~wd[DOR_RSTN_BIT]) | (wr_dsr & wd[DSR_RST_BIT]);
  wire hw_rst     = ~bus_reset_n;
  wire rst_wake   = sw_rst | hw_rst;
  wire acc_wake   = wake_motor | rd_msr | acc_dat;
  wire fdc_wake   = rst_wake | acc_wake;

  wire apd_fdc    = apd_r[PD_FDC_BIT];
  wire tmr_done   = tmr_r >= TMR_W'(IDLE_CYCLES);
  wire fdc_idle   = (dor_r[DOR_MOTOR_LSB+:4] == 4'h0) & (fdc_main_status == MSR_IDLE)
                    & ~fdc_int & fdc_head_unloaded;
  wire fdc_enter  = apd_fdc & fdc_idle & tmr_done & ~fdc_wake;
  wire fdc_pd     = dpd_r[PD_FDC_BIT] | dsr_pd_r | fdc_auto_pd_r;

  // register writes are kept while the unit is down
  always_ff @(posedge clk) begin
    if (rst) begin
      dor_r         <= DOR_RST;
      dpd_r         <= CFG_RST;
      apd_r         <= CFG_RST;
      ppm_r         <= CFG_RST;
      fdc_rate_ctrl <= CFG_RST;
    end else begin
      if (wr_dor) dor_r <= wd;
      if (wr_fire && hit(idx, IDX_DIRECT_PD)) dpd_r <= wd;
      if (wr_fire && hit(idx, IDX_AUTO_PD)) apd_r <= wd;
      if (wr_fire && hit(idx, IDX_PPORT_MODE)) ppm_r <= wd;
      if (wr_dsr || wr_ccr) fdc_rate_ctrl <= wd;
    end
  end

  // rate-register powerdown: set by its bit, left on any wake event
  // a powerdown write wins over a wake in the same cycle, so the request is not lost
  always_ff @(posedge clk) begin
    if (rst) begin
      dsr_pd_r <= 1'b0;
    end else if (wr_dsr && wd[DSR_PD_BIT]) begin
      dsr_pd_r <= 1'b1;
    end else if (fdc_wake) begin
      dsr_pd_r <= 1'b0;
    end
  end

  // idle timer: cleared while disabled, restarted on enable and on every wake
  // saturates at its limit so a long idle spell cannot wrap it
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_r       <= '0;
      apd_fdc_q_r <= 1'b0;
    end else begin
      apd_fdc_q_r <= apd_fdc;
      if (!apd_fdc) begin
        tmr_r <= '0;
      end else if (!apd_fdc_q_r || fdc_wake) begin
        tmr_r <= '0;
      end else if (!tmr_done) begin
        tmr_r <= tmr_r + TMR_W'(1);
      end
    end
  end

  // auto powerdown state of the floppy unit
  always_ff @(posedge clk) begin
    if (rst) begin
      fdc_auto_pd_r <= 1'b0;
    end else if (!apd_fdc || fdc_wake) begin
      fdc_auto_pd_r <= 1'b0;
    end else if (fdc_enter) begin
      fdc_auto_pd_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // read mux: every register reads its live value, even while down
  // ------------------------------------------------------------------
  wire [7:0] pd_status = {2'b00, uart_tx_pd[1] & uart_rx_pd[1], uart_tx_pd[0] & uart_rx_pd[0],
                          pport_ecp_pd, pport_epp_pd, dsr_pd_r, fdc_pd};

  always_comb begin
    unique case (idx)
      IDX_STATUS_A:   rdata_nxt = fdc_status_a;
      IDX_STATUS_B:   rdata_nxt = fdc_status_b;
      IDX_DRV_OUT:    rdata_nxt = dor_r;
      IDX_RATE_MAIN:  rdata_nxt = fdc_main_status;
      IDX_DATA:       rdata_nxt = fdc_rd_data;
      IDX_DIN_RATE:   rdata_nxt = {~disk_change_n, 7'h00};
      IDX_DIRECT_PD:  rdata_nxt = dpd_r;
      IDX_AUTO_PD:    rdata_nxt = apd_r;
      IDX_PD_STATUS:  rdata_nxt = pd_status;
      IDX_PPORT_MODE: rdata_nxt = ppm_r;
      default:        rdata_nxt = 8'h00;              // unmapped reads zero
    endcase
  end

  // bus handshake and strobes to the floppy core
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r         <= 1'b0;
      rdata_r       <= 8'h00;
      fdc_data_rd   <= 1'b0;
      fdc_data_wr   <= 1'b0;
      fdc_wdata     <= 8'h00;
      fdc_reset_req <= 1'b0;
    end else begin
      ack_r         <= req & ~ack_r;
      if (req && !ack_r) rdata_r <= avs_read ? rdata_nxt : 8'h00;
      fdc_data_rd   <= rd_fire & hit(idx, IDX_DATA);
      fdc_data_wr   <= wr_fire & hit(idx, IDX_DATA);
      if (wr_fire && hit(idx, IDX_DATA)) fdc_wdata <= wd;
      fdc_reset_req <= rst_wake;
    end
  end

  // ------------------------------------------------------------------
  // floppy drive pins: motor, select, write data and gate float while down; step, head and density stay driven
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fdd_o            <= '1;
      fdd_oe           <= '0;
      step_direction_n <= 1'b1;
      step_pulse_n     <= 1'b1;
      head_select_n    <= 1'b1;
      density_select   <= 2'b00;
      fdc_powered_down <= 1'b0;
    end else begin
      fdd_o.motor_on_n     <= ~(dor_r[DOR_MOTOR_LSB] | dor_r[DOR_MOTOR_LSB+1]);
      fdd_o.drive_select_n <= dor_r[DOR_DSEL_BIT];
      fdd_o.write_data_n   <= core_write_data_n;
      fdd_o.write_gate_n   <= core_write_gate_n;
      fdd_oe               <= fdc_pd ? '0 : '1;
      step_direction_n     <= core_step_dir_n;
      step_pulse_n         <= core_step_n;
      head_select_n        <= core_head_sel_n;
      density_select       <= core_density;
      fdc_powered_down     <= fdc_pd;
    end
  end

  // ------------------------------------------------------------------
  // uarts: transmitter and receiver auto powerdown, ring watch
  // ------------------------------------------------------------------
  logic [1:0] tx_apd_r;
  logic [1:0] rx_apd_r;
  logic [1:0] sin_q_r;
  logic [1:0] ri_q_r;
  wire  [1:0] sin_chg = uart_serial_input ^ sin_q_r;

  genvar u;
  generate
    for (u = 0; u < 2; u++) begin : g_uart
      wire en = apd_r[PD_UART0_BIT+u];
      // a buffer write in the same cycle as entry wins, so no byte is stranded
      always_ff @(posedge clk) begin
        if (rst) begin
          tx_apd_r[u] <= 1'b0;
          rx_apd_r[u] <= 1'b0;
        end else begin
          if (!en || uart_tx_write[u]) begin
            tx_apd_r[u] <= 1'b0;
          end else if (uart_thr_empty[u] && uart_tsr_empty[u]) begin
            tx_apd_r[u] <= 1'b1;
          end
          if (!en || sin_chg[u]) begin
            rx_apd_r[u] <= 1'b0;
          end else if (uart_rx_fifo_empty[u] && uart_rx_idle[u]) begin
            rx_apd_r[u] <= 1'b1;
          end
        end
      end
      assign uart_tx_pd[u] = dpd_r[PD_UART0_BIT+u] | tx_apd_r[u];
      assign uart_rx_pd[u] = dpd_r[PD_UART0_BIT+u] | rx_apd_r[u];
    end
  endgenerate

  // ring change detection is kept outside the powerdown gating
  always_ff @(posedge clk) begin
    if (rst) begin
      sin_q_r          <= 2'b11;
      ri_q_r           <= 2'b00;
      uart_ring_change <= 2'b00;
    end else begin
      sin_q_r          <= uart_serial_input;
      ri_q_r           <= ring_indicator_input;
      uart_ring_change <= ring_indicator_input ^ ri_q_r;
    end
  end

  // ------------------------------------------------------------------
  // parallel port: evaluated every cycle, so mode changes reach the registered powerdown outputs one clock later
  // ------------------------------------------------------------------
  wire       pp_en   = apd_r[PD_PPORT_BIT];
  wire       cfg_epp = ppm_r[PPM_EPP_BIT];
  wire       cfg_ecp = ppm_r[PPM_ECP_BIT];
  wire [2:0] ecr     = ppm_r[PPM_ECR_LSB+:3];
  wire       epp_off = ~cfg_epp | (cfg_ecp & (ecr != ECR_EPP));
  wire       ecp_off = ~cfg_ecp | (ecr == ECR_SPP) | (ecr == ECR_PS2)
                       | (ecr == ECR_EPP);

  always_ff @(posedge clk) begin
    if (rst) begin
      pport_epp_pd <= 1'b0;
      pport_ecp_pd <= 1'b0;
    end else begin
      pport_epp_pd <= dpd_r[PD_PPORT_BIT] | (pp_en & epp_off);
      pport_ecp_pd <= dpd_r[PD_PPORT_BIT] | (pp_en & ecp_off);
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_msr_read;
    rd_msr;
  endsequence
  sequence s_awake;
    !fdc_auto_pd_r;
  endsequence

  property p_direct_fdc;
    dpd_r[PD_FDC_BIT] |=> fdc_powered_down;
  endproperty
  a_direct_fdc: assert property (p_direct_fdc) else $error("direct floppy powerdown ignored");
  property p_arm_only;
    !apd_fdc |=> !fdc_auto_pd_r;
  endproperty
  a_arm_only: assert property (p_arm_only) else $error("auto down while disarmed");
  property p_enter_cond;
    !$past(fdc_auto_pd_r) && fdc_auto_pd_r |-> $past(fdc_idle) && $past(tmr_done);
  endproperty
  a_enter_cond: assert property (p_enter_cond) else $error("auto down without conditions");
  property p_timer_restart;
    apd_fdc && fdc_wake |=> tmr_r == '0;
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("idle timer not restarted");
  property p_msr_wakes;
    s_msr_read |=> s_awake ##1 (tmr_r == TMR_W'(1) || !apd_fdc);
  endproperty
  a_msr_wakes: assert property (p_msr_wakes) else $error("main status read did not wake");
  property p_dor_no_wake;
    wr_dor && fdc_auto_pd_r && !wake_motor && wd[DOR_RSTN_BIT] && bus_reset_n
      |=> fdc_auto_pd_r;
  endproperty
  a_dor_no_wake: assert property (p_dor_no_wake) else $error("plain output write woke");
  property p_reset_seq;
    sw_rst |=> fdc_reset_req;
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("reset sequence not requested");
  property p_tristate;
    fdc_pd |=> (fdd_oe == '0) ##1 (fdd_oe == '0 || !$past(fdc_pd));
  endproperty
  a_tristate: assert property (p_tristate) else $error("drive outputs not floated");
  property p_rx_wake;
    sin_chg[0] |=> !rx_apd_r[0];
  endproperty
  a_rx_wake: assert property (p_rx_wake) else $error("receiver did not wake");
  property p_tx_wake;
    uart_tx_write[1] |=> !tx_apd_r[1];
  endproperty
  a_tx_wake: assert property (p_tx_wake) else $error("transmitter did not wake");
  property p_ecp_pd;
    pp_en && !cfg_ecp |=> pport_ecp_pd;
  endproperty
  a_ecp_pd: assert property (p_ecp_pd) else $error("ecp logic left powered");
  property p_answer;
    req && !ack_r |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

endmodule

// ==== test/spm_core_model.sv ====
// stand-in for the floppy core and uart receivers beside the power manager
// assumes the bench drives the serial lines on the same clock
`timescale 1ns/10ps
module spm_core_model (
  input  wire logic [1:0] ser_in,  // serial receive lines
  output logic [1:0]      rx_idle, // awaiting start bit
  output logic [7:0]      floppy_main_status,     // main status
  output logic            irq,     // floppy interrupt
  output logic            hunl     // head unload expired
);
  // ------------------------------------------------------------------
  // idle core: ready, no interrupt, heads unloaded
  // ------------------------------------------------------------------
  assign floppy_main_status  = 8'h80;
  assign irq  = 1'b0;
  assign hunl = 1'b1;
  // a low line is a start bit, so the receiver is busy at once
  assign rx_idle = ser_in;
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the power manager
// assumes a short idle timer and the core stand-in model
`timescale 1ns/10ps
`define CHK(n,e,a) begin checks++; if ((a)!==(e)) begin n_mismatch++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_top;
  import spm_pkg::*;
  localparam int IDLE = 20;
  logic clk = 0, rst = 1, rd = 0, wr = 0, bus_reset_n = 1;
  logic [5:0]  adr = '0;
  logic [31:0] wd = '0, rdat;
  logic [1:0]  ser = 2'h3, ring = 2'h0, txw = 2'h0, one = 2'h3;
  logic [7:0]  floppy_main_status, rv;
  logic        irq, hunl, wq, fpd, sdir, epd, cpd;
  logic [1:0]  rxi, txpd, rxpd;
  spm_fdd_drv_t oe, fo;
  logic [3:0]  be = 4'hf;
  logic [7:0]  live = 8'h00, rate, fwd;
  logic        dchg = 1'b1, cdir = 1'b0, rreq;
  logic [1:0]  cden = 2'h2, dens, ringc;
  int n_mismatch = 0, checks = 0;
  spm_core_model spm_core_model_i (.ser_in(ser), .rx_idle(rxi), .floppy_main_status(floppy_main_status), .irq(irq),
    .hunl(hunl));
  spm_power_manager #(.IDLE_CYCLES(IDLE)) spm_power_manager_i (.clk(clk), .rst(rst),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
    .bus_reset_n(bus_reset_n), .fdc_main_status(floppy_main_status), .fdc_int(irq),
    .fdc_head_unloaded(hunl), .fdc_rd_data(live), .fdc_status_a(live),
    .fdc_status_b(8'h00), .disk_change_n(dchg), .fdc_data_rd(), .fdc_data_wr(),
    .fdc_wdata(fwd), .fdc_reset_req(rreq), .fdc_rate_ctrl(rate), .fdc_powered_down(fpd),
    .core_write_data_n(1'b1), .core_write_gate_n(1'b1), .core_step_dir_n(cdir),
    .core_step_n(1'b1), .core_head_sel_n(1'b1), .core_density(cden), .fdd_o(fo),
    .fdd_oe(oe), .step_direction_n(sdir), .step_pulse_n(), .head_select_n(),
    .density_select(dens), .uart_tx_write(txw), .uart_thr_empty(one), .uart_tsr_empty(one),
    .uart_rx_fifo_empty(one), .uart_rx_idle(rxi), .uart_serial_input(ser),
    .ring_indicator_input(ring), .uart_tx_pd(txpd), .uart_rx_pd(rxpd),
    .uart_ring_change(ringc), .pport_epp_pd(epd), .pport_ecp_pd(cpd));
  // ------------------------------------------------------------------
  // clock and bus cycles
  // ------------------------------------------------------------------
  initial forever #2.5 clk = ~clk;
  // request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk);
    adr <= {i, 2'b00}; wd <= {24'h0, d}; wr <= w; rd <= !w;
    @(posedge clk);
    while (wq) @(posedge clk);
    if (!w) rv = rdat[7:0];
    wr <= 0;
    rd <= 0;
  endtask
  task automatic tick(input int n); repeat (n) @(posedge clk); endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_direct;
    acc(1, IDX_DIRECT_PD, 8'h39); tick(3);
    `CHK("fdc_pd", 1'b1, fpd)
    `CHK("tx_pd", 2'h3, txpd)
    `CHK("pp_pd", 2'h3, {epd, cpd})
    be <= 4'h0;
    acc(1, IDX_DIRECT_PD, 8'h00);
    be <= 4'hf;
    acc(0, IDX_DIRECT_PD, 8'h00);
    `CHK("dpd_keep", 8'h39, rv)
    acc(1, IDX_DIRECT_PD, 8'h00); tick(3);
    `CHK("rx_pd", 2'h0, rxpd)
    $display("direct powerdown done");
  endtask
  task automatic t_fdc;
    acc(1, IDX_AUTO_PD, 8'h01); tick(IDLE / 2);
    `CHK("early", 1'b0, fpd)
    tick(IDLE);
    `CHK("fdc_pd", 1'b1, fpd)
    `CHK("oe", 4'h0, oe)
    `CHK("dir", 1'b0, sdir)
    cdir <= 1'b1;
    cden <= 2'h1;
    tick(2);
    `CHK("dir_act", 1'b1, sdir)
    `CHK("den_act", 2'h1, dens)
    live <= 8'ha5;
    dchg <= 1'b0;
    acc(0, IDX_STATUS_A, 8'h00);
    `CHK("sta_live", 8'ha5, rv)
    acc(0, IDX_DIN_RATE, 8'h00);
    `CHK("din_live", 8'h80, rv)
    acc(0, IDX_DRV_OUT, 8'h00); acc(1, IDX_DRV_OUT, 8'h04); tick(3);
    `CHK("dor_val", DOR_RST, rv)
    `CHK("no_wake", 1'b1, fpd)
    acc(0, IDX_RATE_MAIN, 8'h00); tick(3);
    `CHK("msr_live", MSR_IDLE, rv)
    `CHK("woken", 1'b0, fpd)
    `CHK("oe_on", 4'hf, oe)
    tick(IDLE + 5);
    `CHK("again", 1'b1, fpd)
    acc(1, IDX_AUTO_PD, 8'h00); tick(3);
    `CHK("off", 1'b0, fpd)
    $display("floppy auto powerdown done");
  endtask
  task automatic t_wake;
    acc(1, IDX_AUTO_PD, 8'h01);
    tick(IDLE + 5);
    acc(1, IDX_RATE_MAIN, 8'h40);
    tick(2);
    `CHK("rate", 8'h40, rate)
    `CHK("dsr_pd", 1'b1, fpd)
    acc(1, IDX_DATA, 8'h3c);
    tick(3);
    `CHK("wdata", 8'h3c, fwd)
    `CHK("dat_wake", 1'b0, fpd)
    tick(IDLE + 5);
    `CHK("auto_back", 1'b1, fpd)
    acc(1, IDX_DRV_OUT, 8'h14);
    tick(IDLE + 5);
    `CHK("motor", 1'b0, fo.motor_on_n)
    `CHK("mot_wake", 1'b0, fpd)
    acc(1, IDX_DRV_OUT, 8'h04);
    tick(IDLE + 5);
    `CHK("reenter", 1'b1, fpd)
    @(posedge clk);
    bus_reset_n <= 1'b0;
    @(posedge clk);
    bus_reset_n <= 1'b1;
    @(posedge clk);
    `CHK("rst_req", 1'b1, rreq)
    tick(2);
    `CHK("rst_wake", 1'b0, fpd)
    acc(1, IDX_AUTO_PD, 8'h00);
    $display("floppy wake events done");
  endtask
  task automatic t_uart;
    acc(1, IDX_AUTO_PD, 8'h30); tick(4);
    `CHK("tx_pd", 2'h3, txpd)
    `CHK("rx_pd", 2'h3, rxpd)
    @(posedge clk) ser <= 2'h2;
    tick(3);
    `CHK("rx_wake", 2'h2, rxpd)
    @(posedge clk);
    txw <= 2'h2;
    one <= 2'h1;
    @(posedge clk);
    txw <= 2'h0;
    tick(2);
    `CHK("tx_wake", 2'h1, txpd)
    one <= 2'h3;
    ring <= 2'h2;
    tick(2);
    `CHK("ring", 2'h2, ringc)
    $display("uart auto powerdown done");
  endtask
  task automatic t_pport;
    acc(1, IDX_AUTO_PD, 8'h08);
    acc(1, IDX_PPORT_MODE, 8'h13); tick(2);
    `CHK("epp", 2'h1, {epd, cpd})
    acc(1, IDX_PPORT_MODE, 8'h0f); tick(2);
    `CHK("ecp", 2'h2, {epd, cpd})
    $display("parallel port powerdown done");
  endtask
  // ------------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // about 2000 cycles, several times what the scenarios need
  initial begin
    #10000;
    n_mismatch++;
    test_done;
  end
  initial begin
    tick(8);
    rst <= 0;
    t_direct; t_fdc; t_wake; t_uart; t_pport;
    test_done;
  end
endmodule
